// *** psrl_host.sv ***
// Host model that drives the serial load pins of the synthesizer port.
`default_nettype none
module psrl_host (
    input wire logic core_clk,
    output logic ser_data,
    output logic ser_clk,
    output logic ser_en_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Power-up idle: clock low, enable high
    initial begin
        ser_clk = 1'b0;
        ser_en_n = 1'b1;
        ser_data = 1'b0;
    end
    // Pins only move on falling core edges, away from the sampling edge
    task automatic hold(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // One frame of n bits, MSB first; h sets how slow the serial clock runs
    task automatic send(input int n, input logic [31:0] data, input int h);
        int i;
        hold(1);
        ser_en_n = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            hold(h);
            ser_data = data[i];
            hold(h);
            ser_clk = 1'b1;
            hold(h);
            ser_clk = 1'b0;
        end
        hold(h);
        ser_en_n = 1'b1;
        // Released data line shows no stale level
        ser_data = ~ser_data;
        hold(h);
    endtask
    // Enable pulse with no serial clock edges
    task automatic pulse_en();
        hold(1);
        ser_en_n = 1'b0;
        hold(4);
        ser_en_n = 1'b1;
        hold(4);
    endtask
    // Clock edges while enable is high
    task automatic idle_clocks(input int n);
        repeat (n) begin
            hold(4);
            ser_clk = 1'b1;
            hold(4);
            ser_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** psrl_loader.sv ***
// Serial load port with a word FIFO between shifter and register bank.
`default_nettype none

// Small flip-flop FIFO, valid and ready on both sides.
module psrl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];   // Storage, one entry per word
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;       // Occupancy, gives honest full and empty
    logic push, pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers, count and storage
    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Register state
    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= mem_nxt[i];
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (srst)
        cnt_r <= (AW+1)'(DEPTH)) else $error("FIFO count beyond depth");
endmodule

module psrl_loader #(
    parameter int DEPTH = psrl_pkg::FIFO_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic SER_DATA,
    input wire logic SER_CLK,
    input wire logic SER_EN_N,
    output logic CASCADE_OUT,
    output logic CASCADE_OE,
    output logic [psrl_pkg::CFG_W-1:0] CFG_REG,
    output logic [psrl_pkg::REF_W-1:0] REF_FIRST,
    output logic [psrl_pkg::REF_LOW_W-1:0] REF_ACTIVE,
    output logic [psrl_pkg::LOOP_W-1:0] LOOP_REG,
    output logic LOAD_STALL
);
    import psrl_pkg::*;

    // Pin synchronisers, two stages each; stage one is read only by stage two
    logic [2:0] s1_r, s2_r, s3_r;
    logic dat_s, clk_s, en_s, clk_d, en_d;
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            // Preset to idle pin levels (enable high, clock low) so no false edge follows reset
            s1_r <= 3'h4;
            s2_r <= 3'h4;
            s3_r <= 3'h4;
        end else begin
            s1_r <= {SER_EN_N, SER_CLK, SER_DATA};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign dat_s = s2_r[0];
    assign clk_s = s2_r[1];
    assign en_s = s2_r[2];
    assign clk_d = s3_r[1];
    assign en_d = s3_r[2];

    // Edge events derived from synchronised pins, no frequency floor
    logic clk_rise, clk_fall, en_rise;
    assign clk_rise = clk_s && !clk_d && !en_s;
    assign clk_fall = !clk_s && clk_d && !en_s;
    assign en_rise = en_s && !en_d;

    // Shifter state
    logic [SHIFT_W-1:0] sh_r, sh_nxt;   // Shift stages
    logic half_r, half_nxt;             // Half stage driving cascade out
    logic [CNT_W-1:0] cnt_r, cnt_nxt;   // Bits taken this frame
    logic push_v;                       // Word offered to FIFO
    logic [FIFO_W-1:0] push_d;
    logic push_rdy;
    logic held_r, held_nxt;             // Commit waiting for FIFO room

    // Shifter next state
    always_comb begin
        sh_nxt = sh_r;
        half_nxt = half_r;
        cnt_nxt = cnt_r;
        held_nxt = held_r;
        push_v = 1'b0;
        push_d = {TGT_XFER, sh_r};
        // Target chosen purely by length, so all bits are data
        if (cnt_r == CNT_CFG) begin
            push_d = {TGT_CFG, sh_r};
        end else if (cnt_r == CNT_REF) begin
            push_d = {TGT_REF, sh_r};
        end else if (cnt_r == CNT_LOOP) begin
            push_d = {TGT_LOOP, sh_r};
        end
        if (en_rise || held_r) begin
            // Commit on enable rise; other lengths push nothing
            push_v = (cnt_r == CNT_CFG) || (cnt_r == CNT_REF) ||
                     (cnt_r == CNT_LOOP) || (cnt_r == '0);
            if (push_v && !push_rdy) begin
                held_nxt = 1'b1;  // Keep count until room appears
            end else begin
                held_nxt = 1'b0;
                cnt_nxt = '0;
            end
        end else if (en_s) begin
            cnt_nxt = '0;  // Idle port stays initialised
        end else if (clk_rise) begin
            sh_nxt = {sh_r[SHIFT_W-2:0], dat_s};  // MSB arrives first
            if (cnt_r != CNT_MAX) begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end else if (clk_fall) begin
            half_nxt = sh_r[SHIFT_W-1];  // Cascade bit moves on falling edge
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            sh_r <= '0;
            half_r <= 1'b0;
            cnt_r <= '0;
            held_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            half_r <= half_nxt;
            cnt_r <= cnt_nxt;
            held_r <= held_nxt;
        end
    end

    // FIFO decouples the shifter from register loading
    logic pop_v, pop_rdy;
    logic [FIFO_W-1:0] pop_d;
    assign pop_rdy = 1'b1;
    psrl_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .srst(SRST),
        .in_valid(push_v),
        .in_ready(push_rdy),
        .in_data(push_d),
        .out_valid(pop_v),
        .out_ready(pop_rdy),
        .out_data(pop_d)
    );
    assign LOAD_STALL = held_r;

    // Register bank, written only from FIFO words
    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic [REF_W-1:0] ref1_r, ref1_nxt;
    logic [REF_LOW_W-1:0] ref2_r, ref2_nxt;
    logic [LOOP_W-1:0] loop_r, loop_nxt;
    logic [1:0] tgt;
    assign tgt = pop_d[FIFO_W-1 -: 2];

    always_comb begin
        cfg_nxt = cfg_r;
        ref1_nxt = ref1_r;
        ref2_nxt = ref2_r;
        loop_nxt = loop_r;
        if (pop_v) begin
            unique case (tgt)
                TGT_CFG: begin
                    cfg_nxt = pop_d[CFG_W-1:0];
                end
                TGT_REF: begin
                    // Upper bits act at once, low bits wait in first buffer
                    ref1_nxt = pop_d[REF_W-1:0];
                end
                TGT_LOOP: begin
                    loop_nxt = pop_d[LOOP_W-1:0];
                    ref2_nxt = ref1_r[REF_LOW_W-1:0];
                end
                TGT_XFER: begin
                    ref2_nxt = ref1_r[REF_LOW_W-1:0];
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cfg_r <= CFG_RST;
            ref1_r <= REF_RST;
            ref2_r <= REF_RST[REF_LOW_W-1:0];
            loop_r <= LOOP_RST;  // Cascade data output after power-up
        end else begin
            cfg_r <= cfg_nxt;
            ref1_r <= ref1_nxt;
            ref2_r <= ref2_nxt;
            loop_r <= loop_nxt;
        end
    end

    assign CFG_REG = cfg_r;
    assign REF_FIRST = ref1_r;
    assign REF_ACTIVE = ref2_r;
    assign LOOP_REG = loop_r;
    // Driven only while selected as cascade data out
    assign CASCADE_OE = (loop_r[OUTSEL_HI:OUTSEL_LO] == OUTSEL_DOUT);
    assign CASCADE_OUT = half_r;

    shift_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !pop_v |=> $stable(cfg_r) && $stable(loop_r)) else $error("reg changed");
    idle_clear_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        en_s && !en_rise && !held_r |=> cnt_r == '0) else $error("count not cleared");
    odd_len_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        en_rise && cnt_r != CNT_CFG && cnt_r != CNT_REF && cnt_r != CNT_LOOP && cnt_r != '0
        |-> !push_v) else $error("odd length pushed");
    loop_xfer_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        pop_v && tgt == TGT_LOOP |=> ref2_r == $past(ref1_r[REF_LOW_W-1:0]))
        else $error("buffer not transferred");
    pulse_xfer_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        en_rise && cnt_r == '0 && push_rdy |=> ##[0:8] ref2_r == ref1_r[REF_LOW_W-1:0])
        else $error("enable pulse lost");
    ref_low_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        pop_v && tgt == TGT_REF |=> $stable(ref2_r)) else $error("second buffer moved");
    msb_first_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        clk_rise && !en_rise && !held_r && !en_s |=> sh_r[0] == $past(dat_s)
        && sh_r[1] == $past(sh_r[0])) else $error("shift order wrong");
    cascade_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !clk_fall |=> $stable(half_r)) else $error("cascade moved off fall");
endmodule
`default_nettype wire

// *** psrl_loader_test.sv ***
// Self-checking bench for the synthesizer serial load port.
`default_nettype none
module psrl_loader_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk;
    logic srst;
    logic ser_data;
    logic ser_clk;
    logic ser_en_n;
    logic cascade_out;
    logic cascade_oe;
    logic [7:0] cfg_reg;
    logic [15:0] ref_first;
    logic [12:0] ref_active;
    logic [23:0] loop_reg;
    logic load_stall;
    int failures = 0;
    int total_checks = 0;
    psrl_loader i_psrl_loader (
        .CORE_CLK(core_clk), .SRST(srst), .SER_DATA(ser_data), .SER_CLK(ser_clk),
        .SER_EN_N(ser_en_n), .CASCADE_OUT(cascade_out), .CASCADE_OE(cascade_oe),
        .CFG_REG(cfg_reg), .REF_FIRST(ref_first), .REF_ACTIVE(ref_active),
        .LOOP_REG(loop_reg), .LOAD_STALL(load_stall)
    );
    psrl_host i_psrl_host (
        .core_clk(core_clk), .ser_data(ser_data), .ser_clk(ser_clk), .ser_en_n(ser_en_n)
    );
    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Compare and count; four-state compare so unknowns fail
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_reset();
        check(32'(loop_reg), 32'h400000, "loop reset");
        check(32'(cascade_oe), 32'h1, "cascade enable at reset");
        check(32'(cfg_reg), 32'h0, "cfg reset");
        check(32'({ref_first, 3'h0, ref_active}), 32'h0, "ref reset");
        check(32'(load_stall), 32'h0, "stall at reset");
        check(32'(cascade_out), 32'h0, "cascade bit at reset");
    endtask
    // Reset again in mid-run, then the port must load cleanly
    task automatic t_rerst();
        srst = 1'b1;
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        repeat (2) @(negedge core_clk);
        t_reset();
        i_psrl_host.send(8, 32'h5A, 4);
        i_psrl_host.hold(6);
        check(32'(cfg_reg), 32'h5A, "cfg after reset");
        check(32'(ref_active), 32'h0, "ref active after reset");
    endtask
    task automatic t_cfg();
        i_psrl_host.idle_clocks(3);
        i_psrl_host.send(8, 32'hA5, 4);
        i_psrl_host.hold(6);
        check(32'(cfg_reg), 32'hA5, "cfg load");
        check(32'(loop_reg), 32'h400000, "loop kept");
    endtask
    task automatic t_ref();
        i_psrl_host.send(16, 32'hE123, 4);
        i_psrl_host.hold(6);
        check(32'(ref_first), 32'hE123, "ref first");
        check(32'(ref_active), 32'h0, "ref active kept");
        check(32'(cfg_reg), 32'hA5, "cfg kept");
        i_psrl_host.pulse_en();
        i_psrl_host.hold(6);
        check(32'(ref_active), 32'h0123, "ref after pulse");
    endtask
    task automatic t_loop();
        i_psrl_host.send(16, 32'h3456, 4);
        i_psrl_host.hold(6);
        check(32'(ref_active), 32'h0123, "ref active held");
        // Loop words keep the main count at or above the swallow count
        i_psrl_host.send(24, 32'h4ABCDE, 4);
        i_psrl_host.hold(6);
        check(32'(loop_reg), 32'h4ABCDE, "loop load");
        check(32'(ref_active), 32'h1456, "ref with loop");
        check(32'(cascade_oe), 32'h1, "cascade kept");
    endtask
    task automatic t_bad();
        i_psrl_host.send(12, 32'hFFF, 4);
        i_psrl_host.send(32, 32'hFFFFFFFF, 4);
        i_psrl_host.send(25, 32'h1000000, 4);
        i_psrl_host.hold(6);
        check(32'(cascade_out), 32'h0, "cascade bit low");
        check(32'({cfg_reg, loop_reg}), 32'hA54ABCDE, "no update");
        check(32'(ref_first), 32'h3456, "ref no update");
        i_psrl_host.send(25, 32'h0800000, 4);
        i_psrl_host.hold(6);
        check(32'(cascade_out), 32'h1, "cascade bit high");
    endtask
    task automatic t_slow();
        i_psrl_host.send(8, 32'h3C, 40);
        i_psrl_host.hold(6);
        check(32'(cfg_reg), 32'h3C, "slow cfg");
        i_psrl_host.send(24, 32'h012345, 4);
        i_psrl_host.hold(6);
        check(32'(cascade_oe), 32'h0, "cascade off");
        check(32'(ref_active), 32'h1456, "ref with second loop");
        check(32'(load_stall), 32'h0, "no stall");
    endtask
    // Reset for 6 cycles, then the scenarios
    initial begin
        srst = 1'b1;
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        repeat (2) @(negedge core_clk);
        t_reset();
        t_cfg();
        t_ref();
        t_loop();
        t_bad();
        t_slow();
        t_rerst();
        finish_test();
    end
    // Watchdog well beyond the expected run of about 3500 cycles
    initial begin
        #500000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire

// *** psrl_pkg.sv ***
// Package of constants for the synthesizer serial load port.
`default_nettype none
package psrl_pkg;
    localparam int CFG_W = 8;             // Configuration register width
    localparam int REF_W = 16;            // Reference divider register width
    localparam int REF_LOW_W = 13;        // Double-buffered low part of reference divider
    localparam int LOOP_W = 24;           // Loop counter register width
    localparam int SHIFT_W = 24;          // Full stages of the shift register
    localparam int CNT_W = 6;             // Bit counter width, counts up to 63
    localparam logic [5:0] CNT_CFG = 6'h08;   // Bit count that selects configuration
    localparam logic [5:0] CNT_REF = 6'h10;   // Bit count that selects reference divider
    localparam logic [5:0] CNT_LOOP = 6'h18;  // Bit count that selects loop counter
    localparam logic [5:0] CNT_MAX = 6'h3F;   // Counter saturates here
    localparam int OUTSEL_HI = 23;        // Output select high bit in loop counter
    localparam int OUTSEL_LO = 22;        // Output select low bit in loop counter
    localparam logic [1:0] OUTSEL_DOUT = 2'h1;  // Cascade data out selection
    localparam logic [23:0] LOOP_RST = 24'h400000;  // Power-up: cascade data out
    localparam logic [7:0] CFG_RST = 8'h00;   // Configuration register at reset
    localparam logic [15:0] REF_RST = 16'h0000;  // Reference divider at reset
    localparam int FIFO_DEPTH = 8;        // Words buffered between shifter and loader
    localparam int FIFO_W = 26;           // Target code (2) plus 24 data bits
    localparam logic [1:0] TGT_CFG = 2'h0;    // Load configuration register
    localparam logic [1:0] TGT_REF = 2'h1;    // Load reference divider first buffer
    localparam logic [1:0] TGT_LOOP = 2'h2;   // Load loop counter and transfer buffer
    localparam logic [1:0] TGT_XFER = 2'h3;   // Enable pulse only: transfer buffer
endpackage
`default_nettype wire
